// *** rtl/urmp_pkg.sv ***
package urmp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [15:0] CFG2_ADDR      = 16'h8002;
    localparam logic [15:0] MODE_ADDR      = 16'h8006;
    localparam logic [15:0] CTRL_ADDR      = 16'h8040;
    localparam logic [15:0] STAT_ADDR      = 16'h8041;
    localparam logic [15:0] SEL_ADDR       = 16'h8042;
    localparam int          HPP_LSB        = 2;
    localparam int          HPP_MSB        = 6;
    localparam int          STALL_MSB      = 1;
    localparam int          WIDTH_BIT      = 2;
    localparam int          CTRL_DPI8_BIT  = 0;
    localparam int          CTRL_TAG_BIT   = 1;
    localparam logic [7:0]  CTRL_RESET     = 8'h01;
    localparam logic [1:0]  STALL_RESET    = 2'h0;

    // ****************************************
    // Addresses and cell geometry
    // ****************************************
    localparam logic [4:0]  NULL_PHY       = 5'h1F;
    localparam logic [4:0]  FIRST_PHY      = 5'h00;
    localparam logic [4:0]  HPP_RESET      = 5'h1E;
    localparam logic [6:0]  CELL_WORDS_8   = 7'h35;
    localparam logic [6:0]  CELL_WORDS_16  = 7'h1B;
    localparam logic [3:0]  TAG_GAP_8      = 4'h7;
    localparam logic [3:0]  TAG_GAP_16     = 4'h5;

    // ****************************************
    // Clock ratios (core cycles per RCLK)
    // ****************************************
    localparam logic [2:0]  DIV_FULL       = 3'h1;
    localparam logic [2:0]  DIV_HALF       = 3'h2;
    localparam logic [2:0]  DIV_QUARTER    = 3'h4;
    localparam int          LED_HOLD_RCLK  = 4194304;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_XFER,
        ST_PAUSE,
        ST_RESUME,
        ST_GAP
    } urmp_state_t;

    typedef struct packed {
        logic        valid;
        logic        sof;
        logic [15:0] data;
    } urmp_word_t;

endpackage : urmp_pkg

// *** rtl/urmp_rx_poller.sv ***
`timescale 1ns/100ps
`default_nettype none
module urmp_rx_poller #(
    parameter int LED_HOLD_CYCLES = urmp_pkg::LED_HOLD_RCLK
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic [15:0]       reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [7:0]             reg_rdata_out,
    input  wire logic              bus_width_strap_in,
    input  wire logic              clock_dir_strap_in,
    input  wire logic [15:0]       rx_data_in,
    input  wire logic              rsoc_in,
    input  wire logic              rclav_in,
    output logic                   rclk_out,
    output logic                   renb_b_out,
    output logic [4:0]             rx_addr_out,
    output logic                   rx_activity_led_out,
    input  wire logic              dpi_rx_clock_in,
    output logic                   dpi_rx_clock_out,
    output logic                   dpi_rx_clock_oe_out,
    input  wire logic              dpi_space_in,
    output urmp_pkg::urmp_word_t   cell_out
);

    // ****************************************
    // Declarations
    // ****************************************
    logic                  bw_m_q, bw_s_q, cd_m_q, cd_s_q;
    logic                  dck_m_q, dck_s_q, dck_d_q;
    logic                  sp_m_q, sp_s_q;
    logic                  width_q, dir_in_q, space_q, space_d;
    logic [4:0]            hpp_q;
    logic [1:0]            stall_q;
    logic [7:0]            ctrl_q;
    logic [7:0]            rdata_d;
    logic [2:0]            div_q, div_d, ratio;
    logic                  tick, rclk_d;
    urmp_pkg::urmp_state_t st_q, st_d;
    logic [4:0]            addr_q, addr_d;
    logic [4:0]            ptr_q, ptr_d, sel_q, sel_d, held_addr_q, held_addr_d;
    logic                  held_q, held_d, polled_q, polled_d;
    logic                  renb_q, renb_d, renb_prev_q;
    logic [6:0]            req_q, req_d, cell_words;
    logic [3:0]            gap_q, gap_d, tag_gap;
    logic [22:0]           led_q, led_d;
    urmp_pkg::urmp_word_t  word_d;
    logic                  hit, start_held, start_hit;
    logic                  wr_cfg2, wr_mode, wr_ctrl;

    function automatic logic [4:0] next_phy(input logic [4:0] a, input logic [4:0] top);
        next_phy = (a >= top) ? urmp_pkg::FIRST_PHY : 5'(a + 5'h01);
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        bw_m_q  <= bus_width_strap_in;
        bw_s_q  <= bw_m_q;
        cd_m_q  <= clock_dir_strap_in;
        cd_s_q  <= cd_m_q;
        dck_m_q <= dpi_rx_clock_in;
        dck_s_q <= dck_m_q;
        dck_d_q <= dck_s_q;
        sp_m_q  <= dpi_space_in;
        sp_s_q  <= sp_m_q;
    end

    // Space sampled on rising DPI clock edges when that clock is an input
    assign space_d = dir_in_q ? ((dck_s_q && !dck_d_q) ? sp_s_q : space_q) : 1'b1;

    // ****************************************
    // Register bus decode
    // ****************************************
    assign wr_cfg2 = reg_wr_in && (reg_addr_in == urmp_pkg::CFG2_ADDR);
    assign wr_mode = reg_wr_in && (reg_addr_in == urmp_pkg::MODE_ADDR);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == urmp_pkg::CTRL_ADDR);

    always_comb
    begin
        rdata_d = 8'h00;
        if (!reg_rd_in)
            rdata_d = 8'h00;
        else if (reg_addr_in == urmp_pkg::CFG2_ADDR)
            rdata_d = {1'b0, hpp_q, stall_q};
        else if (reg_addr_in == urmp_pkg::MODE_ADDR)
            rdata_d = {5'h00, width_q, 2'h0};
        else if (reg_addr_in == urmp_pkg::CTRL_ADDR)
            rdata_d = ctrl_q;
        else if (reg_addr_in == urmp_pkg::STAT_ADDR)
            rdata_d = {3'h0, held_q, rx_activity_led_out, dir_in_q,
                       (st_q == urmp_pkg::ST_PAUSE), (st_q != urmp_pkg::ST_IDLE)};
        else if (reg_addr_in == urmp_pkg::SEL_ADDR)
            rdata_d = {3'h0, sel_q};
        else
            rdata_d = 8'h00;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            width_q  <= bw_s_q;
            dir_in_q <= cd_s_q;
            hpp_q    <= urmp_pkg::HPP_RESET;
            stall_q  <= urmp_pkg::STALL_RESET;
            ctrl_q   <= urmp_pkg::CTRL_RESET;
            space_q  <= 1'b1;
        end
        else
        begin
            space_q <= space_d;
            if (wr_cfg2)
            begin
                hpp_q   <= reg_wdata_in[urmp_pkg::HPP_MSB:urmp_pkg::HPP_LSB];
                stall_q <= reg_wdata_in[urmp_pkg::STALL_MSB:0];
            end
            if (wr_mode)
                width_q <= reg_wdata_in[urmp_pkg::WIDTH_BIT];
            if (wr_ctrl)
                ctrl_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 8'h00;
        else
            reg_rdata_out <= rdata_d;
    end

    // ****************************************
    // Clock generation
    // ****************************************
    assign ratio = ctrl_q[urmp_pkg::CTRL_DPI8_BIT]
                 ? (width_q ? urmp_pkg::DIV_HALF : urmp_pkg::DIV_FULL)
                 : (width_q ? urmp_pkg::DIV_QUARTER : urmp_pkg::DIV_HALF);
    assign tick   = (div_q >= 3'(ratio - 3'h1));
    assign div_d  = tick ? 3'h0 : 3'(div_q + 3'h1);
    assign rclk_d = (ratio == urmp_pkg::DIV_FULL) || (div_d < (ratio >> 1));

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            div_q               <= 3'h0;
            rclk_out            <= 1'b1;
            dpi_rx_clock_out    <= 1'b1;
            dpi_rx_clock_oe_out <= 1'b0;
        end
        else
        begin
            div_q               <= div_d;
            rclk_out            <= rclk_d;
            dpi_rx_clock_out    <= 1'b1;
            dpi_rx_clock_oe_out <= !dir_in_q;
        end
    end

    // ****************************************
    // Poller and cell transfer
    // ****************************************
    assign cell_words = width_q ? urmp_pkg::CELL_WORDS_16 : urmp_pkg::CELL_WORDS_8;
    assign tag_gap    = width_q ? urmp_pkg::TAG_GAP_16 : urmp_pkg::TAG_GAP_8;
    assign hit        = rclav_in && polled_q && (addr_q != urmp_pkg::NULL_PHY);
    assign start_held = held_q;
    assign start_hit  = hit && !held_q;

    always_comb
    begin
        st_d        = st_q;
        ptr_d       = ptr_q;
        sel_d       = sel_q;
        held_d      = held_q;
        held_addr_d = held_addr_q;
        renb_d      = renb_q;
        req_d       = req_q;
        gap_d       = gap_q;
        polled_d    = 1'b0;
        // Default address: hold a responder, else alternate null and poll
        if (held_q)
            addr_d = held_addr_q;
        else if (addr_q != urmp_pkg::NULL_PHY)
            addr_d = urmp_pkg::NULL_PHY;
        else
        begin
            addr_d   = ptr_q;
            polled_d = 1'b1;
            ptr_d    = next_phy(ptr_q, hpp_q);
        end
        if (hit && !held_q && (st_q != urmp_pkg::ST_IDLE) && (st_q != urmp_pkg::ST_GAP))
        begin
            held_d      = 1'b1;
            held_addr_d = addr_q;
            addr_d      = addr_q;
            polled_d    = 1'b0;
            ptr_d       = ptr_q;
        end
        case (st_q)
            urmp_pkg::ST_IDLE, urmp_pkg::ST_GAP:
            begin
                renb_d = 1'b1;
                if ((st_q == urmp_pkg::ST_GAP) && (gap_q != 4'h0))
                    gap_d = 4'(gap_q - 4'h1);
                else if (start_held || start_hit)
                begin
                    sel_d    = start_held ? held_addr_q : addr_q;
                    addr_d   = sel_d;
                    polled_d = 1'b0;
                    ptr_d    = next_phy(sel_d, hpp_q);
                    held_d   = 1'b0;
                    renb_d   = 1'b0;
                    req_d    = 7'h01;
                    st_d     = urmp_pkg::ST_XFER;
                end
                else
                    st_d = urmp_pkg::ST_IDLE;
            end
            urmp_pkg::ST_XFER:
            begin
                if (req_q >= cell_words)
                begin
                    renb_d = 1'b1;
                    gap_d  = ctrl_q[urmp_pkg::CTRL_TAG_BIT] ? 4'(tag_gap - 4'h2) : 4'h0;
                    st_d   = urmp_pkg::ST_GAP;
                end
                else if (!space_q)
                begin
                    renb_d = 1'b1;
                    st_d   = urmp_pkg::ST_PAUSE;
                end
                else
                begin
                    renb_d = 1'b0;
                    req_d  = 7'(req_q + 7'h01);
                end
            end
            urmp_pkg::ST_PAUSE:
            begin
                renb_d = 1'b1;
                if (space_q)
                begin
                    addr_d   = sel_q;
                    polled_d = 1'b0;
                    ptr_d    = ptr_q;
                    st_d     = urmp_pkg::ST_RESUME;
                end
            end
            urmp_pkg::ST_RESUME:
            begin
                renb_d = 1'b0;
                req_d  = 7'(req_q + 7'h01);
                st_d   = urmp_pkg::ST_XFER;
            end
            default:
            begin
                st_d   = urmp_pkg::ST_IDLE;
                renb_d = 1'b1;
            end
        endcase
    end

    // Word captured for each enable-low cycle one RCLK earlier
    assign word_d.valid = tick && !renb_prev_q;
    assign word_d.sof   = rsoc_in;
    assign word_d.data  = width_q ? rx_data_in : {8'h00, rx_data_in[7:0]};

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            st_q        <= urmp_pkg::ST_IDLE;
            addr_q      <= urmp_pkg::NULL_PHY;
            ptr_q       <= urmp_pkg::FIRST_PHY;
            sel_q       <= urmp_pkg::FIRST_PHY;
            held_q      <= 1'b0;
            held_addr_q <= urmp_pkg::FIRST_PHY;
            polled_q    <= 1'b0;
            renb_q      <= 1'b1;
            renb_prev_q <= 1'b1;
            req_q       <= 7'h00;
            gap_q       <= 4'h0;
        end
        else if (tick)
        begin
            st_q        <= st_d;
            addr_q      <= addr_d;
            ptr_q       <= ptr_d;
            sel_q       <= sel_d;
            held_q      <= held_d;
            held_addr_q <= held_addr_d;
            polled_q    <= polled_d;
            renb_q      <= renb_d;
            renb_prev_q <= renb_q;
            req_q       <= req_d;
            gap_q       <= gap_d;
        end
    end

    assign renb_b_out  = renb_q;
    assign rx_addr_out = addr_q;

    // ****************************************
    // Cell output and activity LED
    // ****************************************
    always_comb
    begin
        led_d = led_q;
        if (word_d.valid && word_d.sof)
            led_d = 23'(LED_HOLD_CYCLES);
        else if (tick && (led_q != 23'h000000))
            led_d = 23'(led_q - 23'h000001);
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            cell_out            <= '0;
            led_q               <= 23'h000000;
            rx_activity_led_out <= 1'b0;
        end
        else
        begin
            cell_out            <= word_d;
            led_q               <= led_d;
            rx_activity_led_out <= (led_d != 23'h000000);
        end
    end

endmodule // urmp_rx_poller
`default_nettype wire

// *** tb/urmp_rx_poller_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module urmp_rx_poller_assertions (
    input wire logic                 sys_clk_in,
    input wire logic                 rst_b_in,
    input wire logic                 reg_rd_in,
    input wire logic [7:0]           reg_rdata_out,
    input wire logic                 clock_dir_strap_in,
    input wire logic                 rclk_out,
    input wire logic                 renb_b_out,
    input wire logic [4:0]           rx_addr_out,
    input wire logic                 rx_activity_led_out,
    input wire logic                 dpi_rx_clock_oe_out,
    input wire urmp_pkg::urmp_word_t cell_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    a_read_slot_only: assert property (reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
        else $error("read data outside read slot");
    a_renb_on_tick: assert property ($changed(renb_b_out) |-> rclk_out)
        else $error("enable moved off the receive clock edge");
    a_addr_on_tick: assert property ($changed(rx_addr_out) |-> rclk_out)
        else $error("address moved off the receive clock edge");
    a_select_addr: assert property ($fell(renb_b_out) |-> $past(rx_addr_out) != 5'h1F
        || rx_addr_out != 5'h1F)
        else $error("enable fell with no port address");
    a_rclk_low_run: assert property ($fell(rclk_out) |-> ##[1:2] rclk_out)
        else $error("receive clock stuck low");
    a_rclk_high_run: assert property ($rose(rclk_out) |-> ##[1:2] !rclk_out)
        else $error("receive clock stuck high");
    a_dir_strap: assert property ($past(rst_b_in) |-> dpi_rx_clock_oe_out == !clock_dir_strap_in)
        else $error("dpi clock direction wrong");
    a_led_on_cell: assert property (cell_out.valid && cell_out.sof
        |-> ##[0:2] rx_activity_led_out)
        else $error("led not lit by a cell");
    c_select: cover property ($fell(renb_b_out));
    c_cell_start: cover property (cell_out.valid && cell_out.sof);
    c_led_on: cover property ($rose(rx_activity_led_out));
endmodule // urmp_rx_poller_assertions

bind urmp_rx_poller urmp_rx_poller_assertions u_urmp_rx_poller_assertions (
    .sys_clk_in, .rst_b_in, .reg_rd_in, .reg_rdata_out, .clock_dir_strap_in, .rclk_out,
    .renb_b_out, .rx_addr_out, .rx_activity_led_out, .dpi_rx_clock_oe_out, .cell_out
);
`default_nettype wire

// *** tb/urmp_phy_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module urmp_phy_model (
    input  wire logic        sys_clk_in,
    input  wire logic        rclk_in,
    input  wire logic        renb_b_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [31:0] want_in,
    output logic             rclav_out,
    output logic             rsoc_out,
    output logic [15:0]      data_out
);
    logic        rclk_q = 1'b1;
    logic        low_q = 1'b0;
    logic        clav_q = 1'b0;
    logic [31:0] sent_q = 32'h0;
    logic [4:0]  own_q = 5'h1F;
    logic [5:0]  idx_q = 6'h00;
    logic [15:0] junk_q = 16'h5A5A;
    logic [15:0] data_q = 16'h0000;
    logic        soc_q = 1'b0;
    logic        tick;
    logic        fresh;
    // ****
    // Selection and data words
    // ****
    assign tick = rclk_in && !rclk_q;
    assign fresh = !renb_b_in && !low_q && want_in[addr_in] && !sent_q[addr_in];
    assign rclav_out = clav_q;
    assign rsoc_out = soc_q;
    assign data_out = data_q;
    always_ff @(posedge sys_clk_in)
    begin
        rclk_q <= rclk_in;
        junk_q <= ~junk_q;
        if (tick)
        begin
            low_q <= !renb_b_in;
            clav_q <= want_in[addr_in] && !sent_q[addr_in];
            // Word follows the edge at which enable was seen low
            if (low_q)
            begin
                data_q <= {5'h00, own_q, idx_q};
                soc_q <= (idx_q == 6'h00);
                idx_q <= idx_q + 6'h01;
            end
            else
            begin
                data_q <= junk_q;
                soc_q <= 1'b0;
            end
            if (fresh)
            begin
                own_q <= addr_in;
                idx_q <= 6'h00;
                sent_q[addr_in] <= 1'b1;
            end
        end
        if (want_in == 32'h0)
            sent_q <= 32'h0;
    end
endmodule // urmp_phy_model
`default_nettype wire

// *** tb/urmp_rx_poller_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module urmp_rx_poller_bench;
    logic                 sys_clk_in = 1'b0;
    logic                 rst_b_in = 1'b0;
    logic [15:0]          reg_addr_in = 16'h0000;
    logic [7:0]           reg_wdata_in = 8'h00;
    logic                 reg_wr_in = 1'b0;
    logic                 reg_rd_in = 1'b0;
    logic [7:0]           reg_rdata_out;
    logic                 bus_width_strap_in = 1'b0;
    logic                 clock_dir_strap_in = 1'b1;
    logic [15:0]          rx_data_in;
    logic                 rsoc_in;
    logic                 rclav_in;
    logic                 rclk_out;
    logic                 renb_b_out;
    logic [4:0]           rx_addr_out;
    logic                 rx_activity_led_out;
    logic                 dpi_rx_clock_in = 1'b0;
    logic                 dpi_rx_clock_out;
    logic                 dpi_rx_clock_oe_out;
    logic                 dpi_space_in = 1'b1;
    urmp_pkg::urmp_word_t cell_out;
    logic [31:0]          want = 32'h0;
    logic [4:0]           prv;
    int                   mismatches = 0;
    int                   n_checks = 0;
    int                   cyc = 0;
    int                   nw = 0;
    int                   lastn = 0;
    int                   n;
    int                   lv;
    urmp_rx_poller #(.LED_HOLD_CYCLES(80)) u_urmp_rx_poller (
        .sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .bus_width_strap_in, .clock_dir_strap_in, .rx_data_in, .rsoc_in,
        .rclav_in, .rclk_out, .renb_b_out, .rx_addr_out, .rx_activity_led_out,
        .dpi_rx_clock_in, .dpi_rx_clock_out, .dpi_rx_clock_oe_out, .dpi_space_in, .cell_out
    );
    urmp_phy_model u_urmp_phy_model (
        .sys_clk_in, .rclk_in(rclk_out), .renb_b_in(renb_b_out), .addr_in(rx_addr_out),
        .want_in(want), .rclav_out(rclav_in), .rsoc_out(rsoc_in), .data_out(rx_data_in)
    );
    initial forever #12.5 sys_clk_in = ~sys_clk_in;
    initial
    begin
        #37;
        forever #100 dpi_rx_clock_in = ~dpi_rx_clock_in;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(16'(reg_rdata_out), 16'(e));
    endtask
    task automatic tk;
        @(posedge rclk_out);
        #1;
    endtask
    task automatic wt(input logic v);
        n = 0;
        while (renb_b_out !== v && n < 300)
        begin
            prv = rx_addr_out;
            tk;
            n++;
        end
    endtask
    task automatic sel(input logic [4:0] p);
        wt(1'b0);
        chk(16'(rx_addr_out), 16'(p));
        tk;
        if (rx_addr_out == 5'h1F)
            tk;
        chk(16'(rx_addr_out), 16'(p == 5'h04 ? 5'h00 : p + 5'h01));
    endtask
    task automatic done(input int w);
        wt(1'b1);
        repeat (3) tk;
        chk(16'(nw), 16'(w));
    endtask
    task automatic ask(input logic [31:0] m);
        @(posedge sys_clk_in) want <= 32'h0;
        @(posedge sys_clk_in) want <= m;
    endtask
    task automatic per(input int e);
        realtime t0;
        @(posedge rclk_out);
        t0 = $realtime;
        @(posedge rclk_out);
        chk(16'(int'(($realtime - t0) / 25.0)), 16'(e));
    endtask
    // ****
    // Monitor and watchdog
    // ****
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            mismatches++;
            results;
        end
        if (cell_out.valid === 1'b1)
        begin
            if (cell_out.sof === 1'b1)
            begin
                lastn = nw;
                nw = 0;
            end
            chk(16'(cell_out.data[5:0]), 16'(nw));
            nw++;
        end
    end
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rc(16'h8002, 8'h78);
        rc(16'h8006, 8'h00);
        rc(16'h8040, 8'h01);
        rc(16'h8041, 8'h04);
        wr(16'h8010, 8'hFF);
        rc(16'h8010, 8'h00);
        wr(16'h8002, 8'h10);
        rc(16'h8002, 8'h10);
        wr(16'h8040, 8'h00);
        per(2);
        prv = rx_addr_out;
        lv = 9;
        repeat (12)
        begin
            tk;
            chk(16'((rx_addr_out == 5'h1F) ^ (prv == 5'h1F)), 16'h1);
            if (rx_addr_out != 5'h1F)
            begin
                if (lv != 9)
                    chk(16'(rx_addr_out), 16'(lv == 4 ? 0 : lv + 1));
                lv = rx_addr_out;
            end
            prv = rx_addr_out;
        end
        ask(32'h2);
        sel(5'h01);
        done(53);
        chk(16'(rx_activity_led_out), 16'h1);
        repeat (20) tk;
        chk(16'(rx_activity_led_out), 16'h1);
        repeat (10) tk;
        chk(16'(rx_activity_led_out), 16'h0);
        ask(32'h1);
        sel(5'h00);
        @(posedge sys_clk_in) want <= 32'h5;
        wt(1'b1);
        chk(16'(rx_addr_out), 16'h2);
        wt(1'b0);
        chk(16'(n), 16'h1);
        sel(5'h02);
        done(53);
        chk(16'(lastn), 16'd53);
        ask(32'h8);
        sel(5'h03);
        repeat (10) tk;
        @(posedge sys_clk_in) dpi_space_in <= 1'b0;
        wt(1'b1);
        repeat (20) tk;
        @(posedge sys_clk_in) dpi_space_in <= 1'b1;
        wt(1'b0);
        chk(16'(prv), 16'h3);
        done(53);
        wr(16'h8006, 8'h04);
        rc(16'h8006, 8'h04);
        per(4);
        ask(32'h10);
        sel(5'h04);
        done(27);
        results;
    end
endmodule // urmp_rx_poller_bench
`default_nettype wire
